//--- logic/fud_collect.sv
// fud_collect: gathers bytes msb first into header and descriptor words
// assumes: take_i only while the owner accepts a byte
`timescale 1ns/10ps
`include "fud_defs.svh"

module fud_collect #(
  parameter int MAXB = 8
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        clr_i,
  input  wire logic        take_i,
  input  wire logic [7:0]  byte_i,
  input  wire logic [3:0]  size_i,
  output logic      [3:0]  cnt_o,
  output logic      [63:0] word_o,
  output logic             word_v_o
);

  logic [63:0] acc_r;
  logic [63:0] acc_nxt;
  logic        last_c;

  if (MAXB < 8 || MAXB > 8)
  begin : g_chk
    $error("fud_collect: MAXB must be 8");
  end

  assign acc_nxt = {acc_r[55:0], byte_i};
  assign last_c  = (cnt_o == size_i - 4'h1);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || (ce_i && clr_i))
    begin
      acc_r    <= 64'h0;
      cnt_o    <= 4'h0;
      word_v_o <= 1'b0;
      word_o   <= 64'h0;
    end
    else if (ce_i)
    begin
      word_v_o <= take_i && last_c;
      if (take_i && last_c)
      begin
        word_o <= acc_nxt;
        acc_r  <= 64'h0;
        cnt_o  <= 4'h0;
      end
      else if (take_i)
      begin
        acc_r <= acc_nxt;
        cnt_o <= cnt_o + 4'h1;
      end
    end
  end

endmodule : fud_collect

//--- logic/fud_defs.svh
// fud_defs.svh: offsets, field positions, codes and reset values of the format decoder
// assumes: included by its bare name from the design files
`ifndef FUD_DEFS_SVH
`define FUD_DEFS_SVH

`define FUD_OPCODE_FORMAT 8'h04
`define FUD_CDB_LAST      3'h5
`define FUD_B1_DEFECT_DATA_FOLLOWS     4
`define FUD_B1_REPLACE_GROWN_LIST     3
`define FUD_B1_FMT_HI     2
`define FUD_B1_FMT_LO     0
`define FUD_FMT_INDEX     3'h4
`define FUD_FMT_PHYS      3'h5
`define FUD_FMT_VENDOR    3'h6
`define FUD_FMT_RSVD      3'h7
`define FUD_HDR_FOV       7
`define FUD_HDR_EXCL      6
`define FUD_HDR_FLAGS_HI  23
`define FUD_HDR_FLAGS_LO  16
`define FUD_HDR_LEN_HI    15
`define FUD_HDR_BYTES     4'h4
`define FUD_LBA_BYTES     4'h4
`define FUD_PHYS_BYTES    4'h8
`define FUD_LBA_SHIFT     2
`define FUD_PHYS_SHIFT    3

`define FUD_REG_CTRL      8'h00
`define FUD_REG_SPARE     8'h04
`define FUD_REG_FACTORY   8'h08
`define FUD_REG_GROWN     8'h0c
`define FUD_REG_STATUS    8'h10
`define FUD_REG_OPTS      8'h14
`define FUD_CTRL_FILL     0
`define FUD_STAT_CHECK    4
`define FUD_STAT_BUSY     5
`define FUD_RST_FILL      1'b0

`endif

//--- logic/fud_format_unit.sv
// fud_format_unit: format command decoder with defect list intake, wishbone registers
// assumes: cdb bytes arrive in order while idle; medium engine answers fmt_done_i
//
// Contract
// - first command byte 04 selects the format command; rest decoded from it.
// - format maps blocks past defects; total defects limited by spare blocks.
// - defect-data flag set means a data-out defect list is taken into map.
// - defect-data flag clear means no data-out phase, no header, no descriptors.
// - supplied entries refer to current block length and logical addresses.
// - replace flag set drops earlier supplied list; new list plus factory defects.
// - replace flag clear adds supplied entries to existing defects.
// - byte 1 bits 2..0 pick logical, physical sector or index offset descriptors.
// - byte 2 is the fill byte, used only when fill enable is set.
// - interleave bytes ignored; one to one interleave always.
// - don't-care command bits accepted at either value, behaviour unchanged.
// - defect list opens with four byte header, length in bytes 2 and 3.
// - logical descriptors are four bytes; length four times count, may be zero.
// - physical and index descriptors are eight bytes; length eight times count.
// - all eight defect handling options also work with physical descriptors.
// - header byte 1 holds options-valid in bit 7, factory exclude in bit 6.
// - options-valid clear uses defaults for bits 4..6; set honours them. Code acts on bit 6 only; bits 5 and 4 have no effect.
// - factory exclude set leaves out the factory map; included by default.
`timescale 1ns/10ps
`include "fud_defs.svh"

module fud_format_unit #(
  parameter int CNT_W = 16
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        cdb_valid_i,
  input  wire logic [7:0]  cdb_byte_i,
  input  wire logic        dout_valid_i,
  input  wire logic [7:0]  dout_byte_i,
  output logic             dout_ready_o,
  output logic             data_out_req_o,
  output logic             defect_valid_o,
  output logic      [63:0] defect_desc_o,
  output logic             defect_phys_o,
  output logic             fmt_start_o,
  input  wire logic        fmt_done_i,
  output logic             fill_en_o,
  output logic      [7:0]  fill_byte_o,
  output logic             use_factory_o,
  output logic             keep_grown_o,
  output logic             status_valid_o,
  output logic             status_check_o
);

  fud_pkg::fud_state_type state_r;
  fud_pkg::fud_state_type state_nxt;

  logic [2:0]       cdb_cnt_r;
  logic [7:0]       opcode_r;
  logic [7:0]       cdb1_r;
  logic [7:0]       cdb2_r;
  logic [7:0]       hdr1_r;
  logic [15:0]      remain_r;
  logic [CNT_W+1:0] need_r;
  logic             check_r;
  logic             fill_pat_en_r;
  logic [CNT_W-1:0] spare_r;
  logic [CNT_W-1:0] factory_r;
  logic [CNT_W-1:0] grown_r;
  logic [31:0]      rd_c;
  logic [31:0]      mrg_c;
  logic             wr_c;
  logic             cdb_take_c;
  logic             cdb_last_c;
  logic             dout_take_c;
  logic [3:0]       col_size_c;
  logic [3:0]       col_cnt;
  logic [63:0]      col_word;
  logic             col_v;
  logic [7:0]       hflags_c;
  logic [15:0]      hlen_c;
  logic             phys_c;
  logic             bad_fmt_c;
  logic             len_bad_c;
  logic [15:0]      prov_c;
  logic             use_fac_c;
  logic             keep_gr_c;
  logic [CNT_W+1:0] need_c;
  logic             over_c;
  logic             go_fmt_c;
  logic             go_err_c;
  logic             ready_nxt;

  if (CNT_W < 16 || CNT_W > 24)
  begin : g_chk
    $error("fud_format_unit: CNT_W must be 16..24");
  end

  function automatic logic [31:0] fud_merge(input logic [31:0] old,
                                            input logic [31:0] dat,
                                            input logic [3:0]  sel);
    logic [31:0] m;
    m = 32'h0;
    for (int i = 0; i < 4; i++)
      m[i*8 +: 8] = {8{sel[i]}};
    return (old & ~m) | (dat & m);
  endfunction : fud_merge

  assign wr_c        = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  // old register value from the read mux, merged with the enabled write bytes
  assign mrg_c       = fud_merge(rd_c, wb_dat_i, wb_sel_i);
  assign cdb_take_c  = cdb_valid_i && (state_r == fud_pkg::S_IDLE || state_r == fud_pkg::S_CDB);
  assign cdb_last_c  = cdb_take_c && (cdb_cnt_r == `FUD_CDB_LAST);
  assign dout_take_c = dout_valid_i && dout_ready_o;

  // format bits
  // only bit 2 splits descriptor size; bits 1..0 are don't-care for logical format
  assign phys_c     = cdb1_r[`FUD_B1_FMT_HI];
  assign bad_fmt_c  = (cdb1_r[`FUD_B1_FMT_HI:`FUD_B1_FMT_LO] == `FUD_FMT_VENDOR) ||
                      (cdb1_r[`FUD_B1_FMT_HI:`FUD_B1_FMT_LO] == `FUD_FMT_RSVD);
  assign col_size_c = (state_r == fud_pkg::S_HDR) ? `FUD_HDR_BYTES :
                      (phys_c ? `FUD_PHYS_BYTES : `FUD_LBA_BYTES);

  assign hflags_c = (state_r == fud_pkg::S_HDR) ?
                    col_word[`FUD_HDR_FLAGS_HI:`FUD_HDR_FLAGS_LO] : 8'h00;
  assign hlen_c   = (state_r == fud_pkg::S_HDR) ? col_word[`FUD_HDR_LEN_HI:0] : 16'h0;

  assign len_bad_c = phys_c ? (hlen_c[`FUD_PHYS_SHIFT-1:0] != 3'h0) :
                              (hlen_c[`FUD_LBA_SHIFT-1:0] != 2'h0);
  assign prov_c    = phys_c ? (hlen_c >> `FUD_PHYS_SHIFT) : (hlen_c >> `FUD_LBA_SHIFT);

  assign use_fac_c = !(hflags_c[`FUD_HDR_FOV] && hflags_c[`FUD_HDR_EXCL]);
  assign keep_gr_c = !(cdb1_r[`FUD_B1_DEFECT_DATA_FOLLOWS] && cdb1_r[`FUD_B1_REPLACE_GROWN_LIST]);

  assign need_c = (CNT_W+2)'(prov_c) +
                  (use_fac_c ? (CNT_W+2)'(factory_r) : (CNT_W+2)'(0)) +
                  (keep_gr_c ? (CNT_W+2)'(grown_r) : (CNT_W+2)'(0));
  assign over_c = need_c > (CNT_W+2)'(spare_r);

  always_comb
  begin
    state_nxt = state_r;
    go_fmt_c  = 1'b0;
    go_err_c  = 1'b0;
    case (state_r)
      fud_pkg::S_IDLE:
        if (cdb_take_c)
          state_nxt = fud_pkg::S_CDB;
      fud_pkg::S_CDB:
        if (cdb_last_c)
        begin
          if (opcode_r != `FUD_OPCODE_FORMAT)
            state_nxt = fud_pkg::S_IDLE;
          else if (cdb1_r[`FUD_B1_DEFECT_DATA_FOLLOWS])
          begin
            go_err_c  = bad_fmt_c;
            state_nxt = bad_fmt_c ? fud_pkg::S_DONE : fud_pkg::S_HDR;
          end
          else
          begin
            go_err_c  = over_c;
            go_fmt_c  = !over_c;
            state_nxt = over_c ? fud_pkg::S_DONE : fud_pkg::S_FMT;
          end
        end
      fud_pkg::S_HDR:
        if (col_v)
        begin
          go_err_c  = len_bad_c || over_c;
          go_fmt_c  = !go_err_c && (hlen_c == 16'h0);
          state_nxt = go_err_c ? fud_pkg::S_DONE :
                      (go_fmt_c ? fud_pkg::S_FMT : fud_pkg::S_DESC);
        end
      fud_pkg::S_DESC:
        if (col_v && remain_r == 16'h0)
        begin
          go_fmt_c  = 1'b1;
          state_nxt = fud_pkg::S_FMT;
        end
      fud_pkg::S_FMT:
        if (fmt_done_i)
          state_nxt = fud_pkg::S_DONE;
      fud_pkg::S_DONE:
        state_nxt = fud_pkg::S_IDLE;
      default:
        state_nxt = fud_pkg::S_IDLE;
    endcase
  end

  assign ready_nxt = (state_nxt == fud_pkg::S_HDR &&
                      !(dout_take_c && col_cnt == col_size_c - 4'h1) && !col_v) ||
                     (state_nxt == fud_pkg::S_DESC &&
                      !(dout_take_c && remain_r == 16'h1) && remain_r != 16'h0);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_r <= fud_pkg::S_IDLE;
    else if (ce_i)
      state_r <= state_nxt;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cdb_cnt_r <= 3'h0;
      opcode_r  <= 8'h00;
      cdb1_r    <= 8'h00;
      cdb2_r    <= 8'h00;
    end
    else if (ce_i && cdb_take_c)
    begin
      cdb_cnt_r <= cdb_last_c ? 3'h0 : cdb_cnt_r + 3'h1;
      case (cdb_cnt_r)
        3'h0: opcode_r <= cdb_byte_i;
        3'h1: cdb1_r   <= cdb_byte_i;
        3'h2: cdb2_r   <= cdb_byte_i;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hdr1_r   <= 8'h00;
      remain_r <= 16'h0;
      need_r   <= '0;
      check_r  <= 1'b0;
    end
    else if (ce_i)
    begin
      if (state_r == fud_pkg::S_IDLE)
        hdr1_r <= 8'h00;
      if (state_r == fud_pkg::S_HDR && col_v)
      begin
        hdr1_r   <= hflags_c;
        remain_r <= hlen_c;
      end
      else if (state_r == fud_pkg::S_DESC && dout_take_c)
        remain_r <= remain_r - 16'h1;
      if ((state_r == fud_pkg::S_CDB && cdb_last_c) || (state_r == fud_pkg::S_HDR && col_v))
        need_r <= need_c;
      if (state_nxt == fud_pkg::S_DONE)
        check_r <= go_err_c;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dout_ready_o   <= 1'b0;
      data_out_req_o <= 1'b0;
    end
    else if (ce_i)
    begin
      dout_ready_o   <= ready_nxt;
      data_out_req_o <= state_nxt == fud_pkg::S_HDR || state_nxt == fud_pkg::S_DESC;
    end
  end

  fud_collect #(
    .MAXB(8)
  ) u_collect (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .ce_i     (ce_i),
    .clr_i    (state_r == fud_pkg::S_IDLE),
    .take_i   (dout_take_c),
    .byte_i   (dout_byte_i),
    .size_i   (col_size_c),
    .cnt_o    (col_cnt),
    .word_o   (col_word),
    .word_v_o (col_v)
  );

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      defect_valid_o <= 1'b0;
      defect_desc_o  <= 64'h0;
      defect_phys_o  <= 1'b0;
    end
    else if (ce_i)
    begin
      defect_valid_o <= state_r == fud_pkg::S_DESC && col_v;
      if (state_r == fud_pkg::S_DESC && col_v)
      begin
        defect_desc_o <= col_word;
        defect_phys_o <= phys_c;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fmt_start_o   <= 1'b0;
      fill_en_o     <= 1'b0;
      fill_byte_o   <= 8'h00;
      use_factory_o <= 1'b1;
      keep_grown_o  <= 1'b1;
    end
    else if (ce_i)
    begin
      fmt_start_o <= go_fmt_c;
      if (go_fmt_c)
      begin
        fill_en_o     <= fill_pat_en_r;
        fill_byte_o   <= cdb2_r;
        use_factory_o <= (state_r == fud_pkg::S_DESC) ?
                         !(hdr1_r[`FUD_HDR_FOV] && hdr1_r[`FUD_HDR_EXCL]) : use_fac_c;
        keep_grown_o  <= keep_gr_c;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      status_valid_o <= 1'b0;
      status_check_o <= 1'b0;
    end
    else if (ce_i)
    begin
      status_valid_o <= state_r == fud_pkg::S_DONE;
      if (state_r == fud_pkg::S_DONE)
        status_check_o <= check_r;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fill_pat_en_r <= `FUD_RST_FILL;
      spare_r       <= '0;
      factory_r     <= '0;
      grown_r       <= '0;
    end
    else if (ce_i && wr_c)
    begin
      if (wb_adr_i == `FUD_REG_CTRL)
        fill_pat_en_r <= mrg_c[`FUD_CTRL_FILL];
      else if (wb_adr_i == `FUD_REG_SPARE)
        spare_r <= mrg_c[CNT_W-1:0];
      else if (wb_adr_i == `FUD_REG_FACTORY)
        factory_r <= mrg_c[CNT_W-1:0];
      else if (wb_adr_i == `FUD_REG_GROWN)
        grown_r <= mrg_c[CNT_W-1:0];
    end
  end

  always_comb
  begin
    rd_c = 32'h0;
    if (wb_adr_i == `FUD_REG_CTRL)
      rd_c[`FUD_CTRL_FILL] = fill_pat_en_r;
    else if (wb_adr_i == `FUD_REG_SPARE)
      rd_c = 32'(spare_r);
    else if (wb_adr_i == `FUD_REG_FACTORY)
      rd_c = 32'(factory_r);
    else if (wb_adr_i == `FUD_REG_GROWN)
      rd_c = 32'(grown_r);
    else if (wb_adr_i == `FUD_REG_STATUS)
    begin
      rd_c[2:0]             = state_r;
      rd_c[`FUD_STAT_CHECK] = check_r;
      rd_c[`FUD_STAT_BUSY]  = state_r != fud_pkg::S_IDLE;
    end
    else if (wb_adr_i == `FUD_REG_OPTS)
      rd_c = {8'h00, cdb2_r, hdr1_r, cdb1_r};
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else if (ce_i)
    begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o)
        wb_dat_o <= wb_we_i ? 32'h0 : rd_c;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_opcode_gate: assert property (fmt_start_o |-> opcode_r == `FUD_OPCODE_FORMAT)
    else $error("format started without format opcode");
  chk_no_dataout: assert property (data_out_req_o |-> cdb1_r[`FUD_B1_DEFECT_DATA_FOLLOWS])
    else $error("data out requested with flag clear");
  chk_bad_format: assert property (fmt_start_o |-> !bad_fmt_c || !cdb1_r[`FUD_B1_DEFECT_DATA_FOLLOWS])
    else $error("format started with bad descriptor format");
  chk_len_multiple: assert property ((state_r == fud_pkg::S_DESC) |->
    (phys_c ? remain_r[2:0] == 3'h0 : remain_r[1:0] == 2'h0) || dout_ready_o == 1'b0
    || $past(state_r) == fud_pkg::S_DESC)
    else $error("descriptor phase entered with odd length");
  chk_replace_grown: assert property ($rose(fmt_start_o) && ce_i |=>
    keep_grown_o == !(cdb1_r[`FUD_B1_DEFECT_DATA_FOLLOWS] && cdb1_r[`FUD_B1_REPLACE_GROWN_LIST]) || !ce_i)
    else $error("grown list handling wrong");
  chk_factory_sel: assert property ($rose(fmt_start_o) |->
    use_factory_o == !(hdr1_r[`FUD_HDR_FOV] && hdr1_r[`FUD_HDR_EXCL]))
    else $error("factory map selection wrong");
  chk_fill_byte: assert property ($rose(fmt_start_o) |->
    fill_byte_o == cdb2_r && fill_en_o == $past(fill_pat_en_r))
    else $error("fill byte or enable wrong");
  chk_spare_limit: assert property (fmt_start_o |-> need_r <= (CNT_W+2)'(spare_r))
    else $error("defects exceed spare blocks");
  chk_wb_ack: assert property (wb_ack_o && ce_i |=> !wb_ack_o || !ce_i)
    else $error("ack held two cycles");

  cov_plain_format: cover property (fmt_start_o && !cdb1_r[`FUD_B1_DEFECT_DATA_FOLLOWS]);
  cov_list_format: cover property (defect_valid_o ##[1:200] fmt_start_o);
  cov_check_cond: cover property (status_valid_o && status_check_o);

endmodule : fud_format_unit

//--- logic/fud_pkg.sv
// fud_pkg: types shared by the format decoder
// assumes: constants live in fud_defs.svh
package fud_pkg;

  typedef enum logic [2:0] {S_IDLE, S_CDB, S_HDR, S_DESC, S_FMT, S_DONE} fud_state_type;

endpackage : fud_pkg

//--- testbench/fud_format_unit_tb.sv
// fud_format_unit_tb: self-checking bench for the format decoder
// assumes: fud_init_model is the initiator; this bench is the medium engine
`timescale 1ns/10ps
`include "fud_defs.svh"

module fud_format_unit_tb;
  logic        clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, fill_v;
  logic        cdb_valid_i, dout_valid_i, dout_ready_o, data_out_req_o, defect_valid_o;
  logic        defect_phys_o, fmt_start_o, fill_en_o, use_factory_o, keep_grown_o;
  logic        status_valid_o, status_check_o;
  logic        fmt_done_i = 1'b0;
  logic        list_cmd   = 1'b0;
  logic [2:0]  done_wait  = 3'h0;
  logic [3:0]  wb_sel_i;
  logic [7:0]  wb_adr_i, cdb_byte_i, dout_byte_i, fill_byte_o;
  logic [31:0] wb_dat_i, wb_dat_o, spare_v, fact_v, grown_v;
  logic [63:0] defect_desc_o;
  logic [31:0] exp_reg [$];
  logic [64:0] exp_def [$];
  logic [10:0] exp_fmt [$];
  logic        exp_st  [$];
  int          miscompares, compares;

  fud_format_unit #(.CNT_W(16)) fud_format_unit_inst (
    .clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .cdb_valid_i, .cdb_byte_i, .dout_valid_i,
    .dout_byte_i, .dout_ready_o, .data_out_req_o, .defect_valid_o, .defect_desc_o,
    .defect_phys_o, .fmt_start_o, .fmt_done_i, .fill_en_o, .fill_byte_o,
    .use_factory_o, .keep_grown_o, .status_valid_o, .status_check_o);

  fud_init_model fud_init_model_inst (
    .clk_i, .dout_ready_i(dout_ready_o), .cdb_valid_o(cdb_valid_i),
    .cdb_byte_o(cdb_byte_i), .dout_valid_o(dout_valid_i), .dout_byte_o(dout_byte_i));

  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic close_out;
    if (exp_reg.size() + exp_def.size() + exp_fmt.size() + exp_st.size() != 0)
      miscompares++;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  task automatic tally(input logic bad, input string what);
    compares++;
    if (bad)
    begin
      miscompares++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask : tally

  task automatic cmp_reg(input logic [31:0] g);
    logic [31:0] e;
    e = exp_reg.size() ? exp_reg.pop_front() : 'x;
    tally(g !== e, "register read");
  endtask : cmp_reg

  task automatic cmp_def(input logic [64:0] g);
    logic [64:0] e;
    e = exp_def.size() ? exp_def.pop_front() : 'x;
    tally(g !== e, "defect descriptor");
  endtask : cmp_def

  task automatic cmp_fmt(input logic [10:0] g);
    logic [10:0] e;
    e = exp_fmt.size() ? exp_fmt.pop_front() : 'x;
    tally(g !== e, "format settings");
  endtask : cmp_fmt

  task automatic cmp_st(input logic g);
    logic e;
    e = exp_st.size() ? exp_st.pop_front() : 1'bx;
    tally(g !== e, "status");
  endtask : cmp_st

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic drain;
    for (int i = 0; i < 400; i++)
    begin
      if (exp_def.size() + exp_fmt.size() + exp_st.size() == 0)
        break;
      @(posedge clk_i);
    end
    repeat (4) @(posedge clk_i);
  endtask : drain

  task automatic fmt_cmd(input logic [7:0] op, b1, h1, input int nd, odd);
    logic [7:0]  c [6];
    logic [7:0]  q [$];
    logic [63:0] d;
    int          dsz, len;
    logic        bad;
    c = '{op, b1, 8'($urandom), 8'($urandom), 8'($urandom), 8'h00};
    dsz = b1[2] ? 8 : 4;
    len = nd * dsz + odd;
    bad = (b1[2:1] == 2'b11) || odd != 0 ||
          nd + ((h1[7] & h1[6]) ? 0 : fact_v) + (b1[3] ? 0 : grown_v) > spare_v;
    if (op == `FUD_OPCODE_FORMAT && !b1[4])
    begin
      exp_fmt.push_back({fill_v, c[2], 2'b11});
      exp_st.push_back(1'b0);
    end
    if (op == `FUD_OPCODE_FORMAT && b1[4])
    begin
      q = '{8'h00, h1, 8'(len >> 8), 8'(len)};
      for (int i = 0; i < nd && !bad; i++)
      begin
        d = {$urandom, $urandom};
        if (!b1[2])
          d[63:32] = 32'h0;
        exp_def.push_back({b1[2], d});
        for (int k = dsz - 1; k >= 0; k--)
          q.push_back(d[8*k +: 8]);
      end
      if (!bad)
        exp_fmt.push_back({fill_v, c[2], !(h1[7] & h1[6]), !b1[3]});
      exp_st.push_back(bad);
    end
    list_cmd <= op == `FUD_OPCODE_FORMAT && b1[4] && b1[2:1] != 2'b11;
    fud_init_model_inst.send_cdb(c);
    if (op == `FUD_OPCODE_FORMAT && b1[4] && b1[2:1] != 2'b11)
      fud_init_model_inst.send_list(q);
    drain();
  endtask : fmt_cmd

  always @(posedge clk_i)
  begin
    fmt_done_i <= (done_wait == 3'h1);
    if (done_wait != 3'h0)
      done_wait <= done_wait - 3'h1;
    if (!rst_i)
    begin
      if (fmt_start_o)
        done_wait <= 3'(2 + $urandom % 5);
      if (wb_ack_o && !wb_we_i) cmp_reg(wb_dat_o);
      if (defect_valid_o) cmp_def({defect_phys_o, defect_phys_o ? defect_desc_o
        : {32'h0, defect_desc_o[31:0]}});
      if (fmt_start_o) cmp_fmt({fill_en_o, fill_byte_o, use_factory_o,
        keep_grown_o});
      if (data_out_req_o) tally(!list_cmd, "data out request");
      if (status_valid_o) cmp_st(status_check_o);
    end
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    close_out();
  end

  initial
  begin
    {rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i} = 5'h18;
    {wb_adr_i, wb_sel_i, wb_dat_i} = {8'h00, 4'hf, 32'h0};
    {spare_v, fact_v, grown_v, fill_v} = {32'h64, 32'h2, 32'h1, 1'b1};
    void'($urandom(32'h6fdce327));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    tally({use_factory_o, keep_grown_o} !== 2'b11, "reset levels");
    wb(1'b1, `FUD_REG_SPARE, spare_v);
    wb(1'b1, `FUD_REG_FACTORY, fact_v);
    wb(1'b1, `FUD_REG_GROWN, grown_v);
    wb(1'b1, `FUD_REG_CTRL, 32'h1);
    wb(1'b1, 8'h40, 32'hffff_ffff);
    exp_reg = '{32'h64, 32'h0, 32'h1};
    wb(1'b0, `FUD_REG_SPARE, 32'h0);
    wb(1'b0, 8'h40, 32'h0);
    wb(1'b0, `FUD_REG_CTRL, 32'h0);
    exp_reg.push_back(spare_v);
    ce_i <= 1'b0;
    fork
      wb(1'b0, `FUD_REG_SPARE, 32'h0);
      begin
        repeat (6)
        begin
          @(posedge clk_i);
          tally(wb_ack_o !== 1'b0, "ack while frozen");
        end
        ce_i <= 1'b1;
      end
    join
    fmt_cmd(8'h12, 8'h10, 8'h00, 1, 0);
    fmt_cmd(8'h04, 8'($urandom & 15), 8'h00, 0, 0);
    wb(1'b1, `FUD_REG_CTRL, 32'h0);
    fill_v = 1'b0;
    fmt_cmd(8'h04, 8'h18 | 8'($urandom & 3), 8'hc0, 2, 0);
    fmt_cmd(8'h04, 8'h10 | 8'($urandom & 3), 8'h40, 1, 0);
    fmt_cmd(8'h04, 8'h15, 8'hc0, 2, 0);
    fmt_cmd(8'h04, 8'h1c, 8'h00, 1, 0);
    fmt_cmd(8'h04, 8'h10, 8'h00, 0, 0);
    fmt_cmd(8'h04, 8'h16, 8'h00, 1, 0);
    fmt_cmd(8'h04, 8'h1f, 8'h00, 1, 0);
    fmt_cmd(8'h04, 8'h10, 8'h00, 1, 2);
    fmt_cmd(8'h04, 8'h15, 8'h00, 1, 4);
    spare_v = 32'h3;
    wb(1'b1, `FUD_REG_SPARE, spare_v);
    fmt_cmd(8'h04, 8'h10, 8'h00, 1, 0);
    fmt_cmd(8'h04, 8'h18, 8'hc0, 3, 0);
    fmt_cmd(8'h04, 8'h18, 8'hc0, 4, 0);
    close_out();
  end
endmodule : fud_format_unit_tb

//--- testbench/fud_init_model.sv
// fud_init_model: initiator side, sends command bytes and defect list bytes
// assumes: target takes command bytes while idle, list bytes on valid and ready
`timescale 1ns/10ps

module fud_init_model (
  input  wire logic       clk_i,
  input  wire logic       dout_ready_i,
  output logic            cdb_valid_o,
  output logic      [7:0] cdb_byte_o,
  output logic            dout_valid_o,
  output logic      [7:0] dout_byte_o
);
  initial
  begin
    cdb_valid_o  = 1'b0;
    cdb_byte_o   = 8'h00;
    dout_valid_o = 1'b0;
    dout_byte_o  = 8'h00;
  end

  task automatic send_cdb(input logic [7:0] b [6]);
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk_i);
      cdb_valid_o <= 1'b1;
      cdb_byte_o  <= b[i];
    end
    @(posedge clk_i);
    cdb_valid_o <= 1'b0;
    cdb_byte_o  <= ~b[5];
  endtask : send_cdb

  task automatic send_list(input logic [7:0] q [$]);
    @(posedge clk_i);
    foreach (q[i])
    begin
      dout_valid_o <= 1'b1;
      dout_byte_o  <= q[i];
      do @(posedge clk_i); while (dout_ready_i !== 1'b1);
    end
    dout_valid_o <= 1'b0;
    dout_byte_o  <= ~q[q.size()-1];
  endtask : send_list
endmodule : fud_init_model
